// ### src/aof_output_format.sv
// Purpose: Output coding, overflow, output enable and power modes of a 10-bit converter
// Assumes: Quantizer delivers offset-binary raw codes and range flags on mclk
// Notes: Registers over AXI4-Lite; pins pass two flip-flops
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module aof_output_format
  import aof_pkg::*;
#(
  parameter int SLEEP_CYC = SLEEP_RECOVERY_CYC, // Sleep recovery in mclk cycles
  parameter int DIV = SAMPLE_DIV                // mclk cycles per sample
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [CODE_W-1:0] rawCode,
  input wire logic overRange,
  input wire logic underRange,
  input wire logic [1:0] modeStrap,
  input wire logic powerDownReq,
  input wire logic outEnableN,
  output logic [CODE_W-1:0] sampleCode,
  output logic sampleCodeOe,
  output logic overflowFlag,
  output logic overflowFlagOe,
  output logic dataValid,
  output logic sampleTick,
  output logic stabilizerOn,
  output logic refPowerOn,
  output logic corePowerOn,
  output logic irq,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [1:0] strapSync;          // Synchronized strap
  logic shdnSync;                 // Synchronized shutdown
  logic oeNSync;                  // Synchronized output enable
  logic [$clog2(DIV+1)-1:0] divCnt_q; // Sample divider
  logic [1:0] settle_q;           // Strap settle counter
  logic strapDone_q;              // Strap latched
  logic twos_q;                   // Two's complement selected
  aof_pwr_e pwr_q;                // Power state
  logic fromSleep_q;              // Recovery started from sleep
  logic [31:0] recCnt_q;          // Recovery countdown
  logic [7:0] lockCnt_q;          // Stabilizer relock countdown
  logic locked;                   // Stabilizer ready
  logic recValid;                 // Data trusted
  logic outsAllowed;              // Not sleeping or napping
  logic [EVT_W-1:0] status_q;     // Sticky events
  logic [EVT_W-1:0] intEn_q;      // Interrupt enables
  logic [EVT_W-1:0] evtSet;       // Events this cycle
  logic [EVT_W-1:0] evtClr;       // Clears this cycle
  logic zeroInvalid_q;            // Drive zero while invalid
  logic validPrev_q;              // Valid edge detect
  logic [ADDR_W-1:0] awAddr_q;    // Held write address
  logic awHeld_q;                 // Write address taken
  logic [31:0] wData_q;           // Held write data
  logic [3:0] wStrb_q;            // Held strobes
  logic wHeld_q;                  // Write data taken
  logic doWrite;                  // Both halves present
  logic [CODE_W-1:0] coded;       // Formatted code

  // Register decode used by both read and write paths
  function automatic logic regHit(input logic [ADDR_W-1:0] a, input logic forWrite);
    case (a)
      REG_STATUS, REG_STATE: regHit = !forWrite;
      REG_INT_ENABLE, REG_CONTROL: regHit = 1'b1;
      REG_INT_CLEAR: regHit = forWrite;
      default: regHit = 1'b0;
    endcase
  endfunction : regHit

  // ************************************************************
  // Pin synchronizers
  // ************************************************************
  aof_sync2 #(.WIDTH(4)) uPinSync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .asyncIn({modeStrap, powerDownReq, outEnableN}),
    .syncOut({strapSync, shdnSync, oeNSync})
  );

  // ************************************************************
  // Sample rate divider
  // ************************************************************
  // One tick per sample period
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      divCnt_q <= '0;
      sampleTick <= 1'b0;
    end
    else if (divCnt_q == ($clog2(DIV+1))'(DIV - 1))
    begin
      divCnt_q <= '0;
      sampleTick <= 1'b1;
    end
    else
    begin
      divCnt_q <= divCnt_q + 1'b1;
      sampleTick <= 1'b0;
    end
  end

  // ************************************************************
  // Mode strap latch
  // ************************************************************
  // Caught once after the synchronizer has settled
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      settle_q <= '0;
      strapDone_q <= 1'b0;
      twos_q <= 1'b0;
      stabilizerOn <= 1'b0;
    end
    else if (!strapDone_q)
    begin
      if (settle_q == 2'(STRAP_SETTLE - 1))
      begin
        strapDone_q <= 1'b1;
        twos_q <= (strapSync == STRAP_TWO_THIRD) || (strapSync == STRAP_SUPPLY);
        stabilizerOn <= (strapSync == STRAP_THIRD) || (strapSync == STRAP_TWO_THIRD);
      end
      else
      begin
        settle_q <= settle_q + 1'b1;
      end
    end
  end

  // ************************************************************
  // Power state machine
  // ************************************************************
  // Shutdown with output enable picks sleep or nap
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pwr_q <= PWR_NORMAL;
      fromSleep_q <= 1'b0;
      recCnt_q <= '0;
    end
    else
    begin
      case (pwr_q)
        PWR_NORMAL, PWR_RECOVER:
        begin
          if (shdnSync && oeNSync)
          begin
            pwr_q <= PWR_SLEEP;
          end
          else if (shdnSync)
          begin
            pwr_q <= PWR_NAP;
          end
          else if (pwr_q == PWR_RECOVER)
          begin
            // Sleep counts mclk, nap counts samples
            if (recCnt_q == '0)
            begin
              pwr_q <= PWR_NORMAL;
            end
            else if (fromSleep_q || sampleTick)
            begin
              recCnt_q <= recCnt_q - 1'b1;
            end
          end
        end
        PWR_SLEEP:
        begin
          // Reference lost: long recovery
          if (!shdnSync)
          begin
            pwr_q <= PWR_RECOVER;
            fromSleep_q <= 1'b1;
            recCnt_q <= 32'(SLEEP_CYC - 1);
          end
          else if (!oeNSync)
          begin
            pwr_q <= PWR_NAP;
          end
        end
        PWR_NAP:
        begin
          // Reference kept: short recovery
          if (!shdnSync)
          begin
            pwr_q <= PWR_RECOVER;
            fromSleep_q <= 1'b0;
            recCnt_q <= 32'(NAP_RECOVERY_TICKS - 1);
          end
          else if (oeNSync)
          begin
            pwr_q <= PWR_SLEEP;
          end
        end
        default:
        begin
          pwr_q <= PWR_NORMAL;
        end
      endcase
    end
  end

  // ************************************************************
  // Stabilizer relock
  // ************************************************************
  // Clock gone while powered down, so relock on every wake
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lockCnt_q <= 8'(RELOCK_TICKS);
    end
    else if (pwr_q == PWR_SLEEP || pwr_q == PWR_NAP || !strapDone_q)
    begin
      lockCnt_q <= 8'(RELOCK_TICKS);
    end
    else if (sampleTick && lockCnt_q != '0)
    begin
      lockCnt_q <= lockCnt_q - 1'b1;
    end
  end

  assign locked = !stabilizerOn || (lockCnt_q == '0);
  assign recValid = strapDone_q && (pwr_q == PWR_NORMAL) && locked;
  assign outsAllowed = (pwr_q == PWR_NORMAL) || (pwr_q == PWR_RECOVER);

  // ************************************************************
  // Output coding
  // ************************************************************
  // Saturate on range error, then choose format
  always_comb
  begin
    coded = rawCode;
    if (overRange)
    begin
      coded = CODE_MAX;
    end
    else if (underRange)
    begin
      coded = CODE_MIN;
    end
    if (twos_q)
    begin
      coded[CODE_MSB] = ~coded[CODE_MSB];
    end
  end

  // One new code per sample tick while converting
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sampleCode <= '0;
      overflowFlag <= 1'b0;
      dataValid <= 1'b0;
    end
    else if (sampleTick && outsAllowed)
    begin
      sampleCode <= (zeroInvalid_q && !recValid) ? '0 : coded;
      overflowFlag <= overRange || underRange;
      dataValid <= recValid;
    end
    else if (!outsAllowed)
    begin
      dataValid <= 1'b0;
    end
  end

  // ************************************************************
  // Output drivers and power controls
  // ************************************************************
  // Enables low in sleep, nap or with output enable high
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sampleCodeOe <= 1'b0;
      overflowFlagOe <= 1'b0;
      refPowerOn <= 1'b0;
      corePowerOn <= 1'b0;
    end
    else
    begin
      sampleCodeOe <= outsAllowed && !oeNSync;
      overflowFlagOe <= outsAllowed && !oeNSync;
      refPowerOn <= (pwr_q != PWR_SLEEP);
      corePowerOn <= outsAllowed;
    end
  end

  // ************************************************************
  // Events and interrupt
  // ************************************************************
  always_comb
  begin
    evtSet = '0;
    evtSet[EVT_OVERFLOW] = sampleTick && outsAllowed && (overRange || underRange);
    evtSet[EVT_SLEEP] = (pwr_q != PWR_SLEEP) && shdnSync && oeNSync;
    evtSet[EVT_NAP] = (pwr_q != PWR_NAP) && shdnSync && !oeNSync;
    evtSet[EVT_VALID] = recValid && !validPrev_q;
    evtClr = '0;
    if (doWrite && awAddr_q == REG_INT_CLEAR && wStrb_q[0])
    begin
      evtClr = wData_q[EVT_W-1:0];
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      status_q <= '0;
      validPrev_q <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      status_q <= (status_q & ~evtClr) | evtSet;
      validPrev_q <= recValid;
      irq <= |(((status_q & ~evtClr) | evtSet) & intEn_q);
    end
  end

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

  // Address and data taken in either order
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
      wHeld_q <= 1'b0;
      wData_q <= '0;
      wStrb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !awHeld_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !wHeld_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= regHit(awAddr_q, 1'b1) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
      end
    end
  end

  // Writable control registers, low byte lane only
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      intEn_q <= '0;
      zeroInvalid_q <= 1'b0;
    end
    else if (doWrite && wStrb_q[0])
    begin
      if (awAddr_q == REG_INT_ENABLE)
      begin
        intEn_q <= wData_q[EVT_W-1:0];
      end
      if (awAddr_q == REG_CONTROL)
      begin
        zeroInvalid_q <= wData_q[CTL_ZERO_INVALID];
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= regHit(s_axi_araddr, 1'b0) ? RESP_OKAY : RESP_SLVERR;
        case (s_axi_araddr)
          REG_STATUS: s_axi_rdata <= 32'(status_q);
          REG_INT_ENABLE: s_axi_rdata <= 32'(intEn_q);
          REG_STATE: s_axi_rdata <= 32'({pwr_q, sampleCodeOe, recValid, stabilizerOn, twos_q});
          REG_CONTROL: s_axi_rdata <= 32'(zeroInvalid_q);
          default: s_axi_rdata <= '0;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : aof_output_format

// ### src/aof_pkg.sv
// Purpose: Shared constants for the converter output format and power mode block
// Assumes: 100 MHz mclk, 32-bit AXI4-Lite register bus
// Notes: Offsets are byte addresses of aligned 32-bit words
package aof_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;            // mclk period
  localparam int SLEEP_RECOVERY_NS = 1000000;   // Reference recharge after sleep
  localparam int SLEEP_RECOVERY_CYC = (SLEEP_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NAP_RECOVERY_TICKS = 100;      // Sample clocks after nap
  localparam int RELOCK_TICKS = 100;            // Stabilizer relock sample clocks
  localparam int SAMPLE_DIV = 2;                // mclk cycles per sample

  // ************************************************************
  // Code layout
  // ************************************************************
  localparam int CODE_W = 10;
  localparam int CODE_MSB = CODE_W - 1;
  localparam logic [CODE_W-1:0] CODE_MAX = 10'h3ff;  // All ones
  localparam logic [CODE_W-1:0] CODE_MIN = 10'h000;  // All zeros

  // ************************************************************
  // Mode strap levels
  // ************************************************************
  localparam logic [1:0] STRAP_GND = 2'h0;      // Offset binary, stabilizer off
  localparam logic [1:0] STRAP_THIRD = 2'h1;    // Offset binary, stabilizer on
  localparam logic [1:0] STRAP_TWO_THIRD = 2'h2; // Two's complement, stabilizer on
  localparam logic [1:0] STRAP_SUPPLY = 2'h3;   // Two's complement, stabilizer off
  localparam int STRAP_SETTLE = 3;              // Cycles after reset release to latch

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;     // Sticky events, read only
  localparam logic [ADDR_W-1:0] REG_INT_ENABLE = 8'h04; // Interrupt enables
  localparam logic [ADDR_W-1:0] REG_INT_CLEAR = 8'h08;  // Write one to clear
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h0c;      // Live state, read only
  localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h10;    // Output control

  localparam int EVT_W = 4;
  localparam int EVT_OVERFLOW = 0;
  localparam int EVT_SLEEP = 1;
  localparam int EVT_NAP = 2;
  localparam int EVT_VALID = 3;

  localparam int ST_TWOS = 0;
  localparam int ST_STAB = 1;
  localparam int ST_VALID = 2;
  localparam int ST_OE = 3;
  localparam int ST_PWR_LSB = 4;
  localparam int ST_W = 6;

  localparam int CTL_ZERO_INVALID = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {PWR_NORMAL, PWR_SLEEP, PWR_NAP, PWR_RECOVER} aof_pwr_e;

endpackage : aof_pkg

// ### src/aof_sync2.sv
// Purpose: Two flip-flop synchronizer for pin levels
// Assumes: Inputs are static or slow against mclk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module aof_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q; // First stage

  // ************************************************************
  // Two stage capture
  // ************************************************************
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q <= '0;
      syncOut <= '0;
    end
    else
    begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule : aof_sync2

// ### verif/aof_capture.sv
// Purpose: Downstream capture logic watching the output pins
// Assumes: Outputs settle the cycle after a sample tick
// Notes: An undriven pin floats to the inverse of its last level
`timescale 1ns/1ps
module aof_capture
  import aof_pkg::*;
(
  input wire logic mclk,
  input wire logic sampleTick,
  input wire logic [CODE_W-1:0] sampleCode,
  input wire logic sampleCodeOe,
  input wire logic overflowFlag,
  input wire logic overflowFlagOe,
  output logic [CODE_W-1:0] capCode,
  output logic capOvf,
  output int capCount
);
  logic [CODE_W-1:0] lastQ = '0; // Last level on the code wire
  logic tickQ = 1'b0; // Capture strobe
  logic [CODE_W-1:0] wireCode; // Resolved code wire
  logic wireOvf; // Resolved flag wire
  // Released wires drift away from the last level
  assign wireCode = sampleCodeOe ? sampleCode : ~lastQ;
  assign wireOvf = overflowFlagOe ? overflowFlag : ~capOvf;
  initial
  begin
    capCode = '0;
    capOvf = 1'b0;
    capCount = 0;
  end
  // Latch one code per sample while driven
  always @(posedge mclk)
  begin
    tickQ <= sampleTick;
    lastQ <= wireCode;
    if (tickQ && sampleCodeOe)
    begin
      capCode <= wireCode;
      capOvf <= wireOvf;
      capCount <= capCount + 1;
    end
  end
endmodule : aof_capture

// ### verif/aof_output_format_sva.sv
// Purpose: Port assertions for the output format block
// Assumes: One mclk domain, sys_rst async active high
// Notes: Bound to the design top below the module
`timescale 1ns/1ps
module aof_output_format_chk
  import aof_pkg::*;
#(
  parameter int DIV = SAMPLE_DIV // Cycles per sample
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic overRange,
  input wire logic underRange,
  input wire logic powerDownReq,
  input wire logic outEnableN,
  input wire logic [CODE_W-1:0] sampleCode,
  input wire logic sampleCodeOe,
  input wire logic overflowFlag,
  input wire logic overflowFlagOe,
  input wire logic dataValid,
  input wire logic sampleTick,
  input wire logic refPowerOn,
  input wire logic corePowerOn
);
  // ****************
  // Helpers
  // ****************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  int gapQ; // Cycles since last tick
  logic seenQ; // First tick seen
  // Tick spacing counter
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gapQ <= 0;
      seenQ <= 1'b0;
    end
    else if (sampleTick)
    begin
      gapQ <= 0;
      seenQ <= 1'b1;
    end
    else
      gapQ <= gapQ + 1;
  end
  sequence s_take; sampleTick && corePowerOn; endsequence
  sequence s_sleepReq; (powerDownReq && outEnableN) [*5]; endsequence
  sequence s_napReq; (powerDownReq && !outEnableN) [*5]; endsequence
  sequence s_runReq; (!powerDownReq && !outEnableN) [*5] ##0 corePowerOn; endsequence
  // ****************
  // Properties
  // ****************
  property p_over;
    s_take ##0 overRange |=> overflowFlag && (!dataValid || sampleCode[8:0] == 9'h1ff);
  endproperty
  property p_under;
    s_take ##0 (underRange && !overRange) |=> overflowFlag && (!dataValid || sampleCode[8:0] == 9'h0);
  endproperty
  property p_inRange; s_take ##0 (!underRange && !overRange) |=> !overflowFlag; endproperty
  property p_oePin; outEnableN [*5] |-> !sampleCodeOe && !overflowFlagOe; endproperty
  property p_oePair; sampleCodeOe == overflowFlagOe; endproperty
  property p_sleep; s_sleepReq |-> !refPowerOn && !sampleCodeOe; endproperty
  property p_nap; s_napReq |-> refPowerOn && !corePowerOn && !overflowFlagOe; endproperty
  property p_run; s_runReq |-> sampleCodeOe; endproperty
  property p_validOff; !corePowerOn [*2] |-> !dataValid; endproperty
  property p_tick; sampleTick && seenQ |-> gapQ == DIV - 1; endproperty
  a_over: assert property (p_over)
    else $error("code not max");
  a_under: assert property (p_under)
    else $error("code not min");
  a_inRange: assert property (p_inRange)
    else $error("flag in range");
  a_oePin: assert property (p_oePin)
    else $error("driven, oe high");
  a_oePair: assert property (p_oePair)
    else $error("enables differ");
  a_sleep: assert property (p_sleep)
    else $error("no sleep");
  a_nap: assert property (p_nap)
    else $error("no nap");
  a_run: assert property (p_run)
    else $error("not driven");
  a_validOff: assert property (p_validOff)
    else $error("valid while down");
  a_tick: assert property (p_tick)
    else $error("tick spacing");
endmodule : aof_output_format_chk

bind aof_output_format aof_output_format_chk #(.DIV(DIV)) u_chk (.mclk, .sys_rst, .overRange,
  .underRange, .powerDownReq, .outEnableN, .sampleCode, .sampleCodeOe, .overflowFlag,
  .overflowFlagOe, .dataValid, .sampleTick, .refPowerOn, .corePowerOn);

// ### verif/aof_output_format_tb_top.sv
// Purpose: Self-checking bench for the output format block
// Assumes: 100 MHz mclk, short sleep recovery parameter
// Notes: Capture model watches the output pins
`timescale 1ns/1ps
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin nMismatch++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module aof_output_format_tb_top
  import aof_pkg::*;
;
  localparam int SIM_SLEEP = 50; // Short sleep recovery
  int nMismatch = 0;
  int numChecks = 0;
  logic mclk = 1'b0;
  logic sysRst = 1'b1;
  logic [CODE_W-1:0] rawCode = '0;
  logic overRange = 1'b0, underRange = 1'b0, powerDownReq = 1'b0, outEnableN = 1'b0;
  logic [1:0] modeStrap = 2'h0;
  logic [ADDR_W-1:0] awAddr = '0;
  logic [ADDR_W-1:0] arAddr = '0;
  logic [31:0] wData = '0;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  logic [CODE_W-1:0] sampleCode, capCode;
  logic sampleCodeOe, overflowFlag, overflowFlagOe, dataValid, sampleTick;
  logic stabilizerOn, refPowerOn, corePowerOn, irq, capOvf;
  int capCount;
  // 100 MHz clock
  always #5 mclk = ~mclk;
  aof_output_format #(.SLEEP_CYC(SIM_SLEEP), .DIV(2)) dut (.mclk, .sys_rst(sysRst), .rawCode,
    .overRange, .underRange, .modeStrap, .powerDownReq, .outEnableN, .sampleCode,
    .sampleCodeOe, .overflowFlag, .overflowFlagOe, .dataValid, .sampleTick, .stabilizerOn,
    .refPowerOn, .corePowerOn, .irq, .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));
  aof_capture cap (.mclk, .sampleTick, .sampleCode, .sampleCodeOe, .overflowFlag,
    .overflowFlagOe, .capCode, .capOvf, .capCount);
  // ****************
  // Shared tasks
  // ****************
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task finish_test();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task limit(input int i, input int lim);
    if (i >= lim)
    begin
      nMismatch++;
      $display("ERROR wait expected done seen timeout");
      finish_test();
    end
  endtask : limit
  task do_reset(input logic [1:0] s);
    sysRst <= 1'b1;
    modeStrap <= s;
    cyc(5);
    sysRst <= 1'b0;
    cyc(8);
  endtask : do_reset
  task axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (i = 0; i < 100 && bValid !== 1'b1; i++)
    begin
      @(posedge mclk);
      if (awReady)
        awValid <= 1'b0;
      if (wReady)
        wValid <= 1'b0;
    end
    limit(i, 100);
    r = bResp;
    bReady <= 1'b0;
    @(posedge mclk);
  endtask : axi_wr
  task rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] m, e, input logic [1:0] er);
    int i;
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (i = 0; i < 100 && rValid !== 1'b1; i++)
    begin
      @(posedge mclk);
      if (arReady)
        arValid <= 1'b0;
    end
    limit(i, 100);
    `CHK("rresp", er, rResp)
    if (er === RESP_OKAY)
      `CHK("rdata", e, rData & m)
    rReady <= 1'b0;
    @(posedge mclk);
  endtask : rd_chk
  // ****************
  // Scenarios
  // ****************
  task t_regs();
    logic [1:0] r;
    rd_chk(REG_INT_ENABLE, 32'hffff_ffff, 32'h0, RESP_OKAY);
    rd_chk(REG_CONTROL, 32'hffff_ffff, 32'h0, RESP_OKAY);
    rd_chk(8'h20, 32'h0, 32'h0, RESP_SLVERR);
    rd_chk(REG_INT_CLEAR, 32'h0, 32'h0, RESP_SLVERR);
    axi_wr(REG_STATUS, 32'hf, r);
    `CHK("bresp", RESP_SLVERR, r)
    axi_wr(REG_INT_ENABLE, 32'hffff_ffff, r);
    rd_chk(REG_INT_ENABLE, 32'hffff_ffff, 32'hf, RESP_OKAY);
    overRange <= 1'b1;
    cyc(6);
    `CHK("irq", 1'b1, irq)
    rd_chk(REG_STATUS, 32'h1, 32'h1, RESP_OKAY);
    axi_wr(REG_INT_ENABLE, 32'h0, r);
    cyc(2);
    `CHK("irq masked", 1'b0, irq)
    overRange <= 1'b0;
    cyc(4);
    axi_wr(REG_INT_CLEAR, 32'h1, r);
    axi_wr(REG_INT_ENABLE, 32'h1, r);
    cyc(2);
    `CHK("irq cleared", 1'b0, irq)
    rd_chk(REG_STATUS, 32'h1, 32'h0, RESP_OKAY);
  endtask : t_regs
  task t_format();
    logic [CODE_W-1:0] e;
    int n;
    for (int s = 0; s < 4; s++)
    begin
      do_reset(s[1:0]);
      `CHK("stabilizer", (s == 1 || s == 2), stabilizerOn)
      for (int k = 0; k < 5; k++)
      begin
        rawCode <= (k == 0) ? 10'h200 : (k == 1) ? 10'h3ff : (k == 2) ? 10'h000 : 10'h155;
        overRange <= (k == 3);
        underRange <= (k == 4);
        e = (k == 0) ? 10'h200 : (k == 1 || k == 3) ? 10'h3ff : 10'h000;
        e = s[1] ? (e ^ 10'h200) : e;
        cyc(6);
        `CHK("code", e, sampleCode)
        `CHK("flag", (k > 2), overflowFlag)
        `CHK("captured", e, capCode)
        `CHK("capFlag", (k > 2), capOvf)
      end
      n = capCount;
      cyc(20);
      `CHK("samples", 10, capCount - n)
    end
    underRange <= 1'b0;
  endtask : t_format
  task t_oe();
    outEnableN <= 1'b1;
    cyc(6);
    `CHK("codeOe", 1'b0, sampleCodeOe)
    `CHK("flagOe", 1'b0, overflowFlagOe)
    `CHK("power", 1'b1, corePowerOn)
    outEnableN <= 1'b0;
    cyc(6);
    `CHK("codeOe", 1'b1, sampleCodeOe)
  endtask : t_oe
  task t_nap();
    logic [1:0] r;
    int i, n;
    axi_wr(REG_INT_ENABLE, 32'h4, r);
    powerDownReq <= 1'b1;
    cyc(8);
    `CHK("codeOe", 1'b0, sampleCodeOe)
    `CHK("ref", 1'b1, refPowerOn)
    `CHK("core", 1'b0, corePowerOn)
    `CHK("valid", 1'b0, dataValid)
    `CHK("irq", 1'b1, irq)
    powerDownReq <= 1'b0;
    n = 0;
    for (i = 0; i < 600 && dataValid !== 1'b1; i++)
    begin
      @(posedge mclk);
      n += sampleTick;
    end
    limit(i, 600);
    `CHK("nap ticks", 1'b1, (n >= NAP_RECOVERY_TICKS - 2 && n <= NAP_RECOVERY_TICKS + 6))
    axi_wr(REG_INT_CLEAR, 32'h4, r);
    cyc(2);
    `CHK("irq", 1'b0, irq)
    `CHK("codeOe", 1'b1, sampleCodeOe)
  endtask : t_nap
  task t_sleep();
    int i;
    outEnableN <= 1'b1;
    powerDownReq <= 1'b1;
    cyc(8);
    `CHK("ref", 1'b0, refPowerOn)
    `CHK("flagOe", 1'b0, overflowFlagOe)
    powerDownReq <= 1'b0;
    for (i = 0; i < 500 && dataValid !== 1'b1; i++)
      @(posedge mclk);
    limit(i, 500);
    `CHK("sleep wait", 1'b1, (i >= SIM_SLEEP && i <= SIM_SLEEP + 12))
    outEnableN <= 1'b0;
    cyc(6);
    `CHK("codeOe", 1'b1, sampleCodeOe)
  endtask : t_sleep
  // Main sequence
  initial
  begin
    @(posedge mclk);
    do_reset(2'h0);
    t_regs();
    t_format();
    t_oe();
    t_nap();
    t_sleep();
    finish_test();
  end
endmodule : aof_output_format_tb_top
